// File: core/dlpc_bank.sv
// Register bank and decode for the delay-reduction loop, pairs 1-8.
// Assumes a register port from the serial interface, synchronous to
// core_clk, and one switching pulse per bridge pair from the gate stage.
`include "dlpc_defs.svh"
`default_nettype none

module dlpc_bank
    import dlpc_pkg::*;
(
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Register port
    input wire logic [5:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Gate stage side: 0=hb12, 1=hb34, 2=hb56, 3=hb78
    input wire logic [3:0] switch_edge,
    input wire logic [5:0] onoff_delay_setting_hb56,
    input wire logic [5:0] onoff_delay_setting_hb78,
    output dlpc_loop_type [3:0] loop_cfg,
    output dlpc_pre_type [1:0] pre_cfg
);

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic [7:0] pre_hb56_reg;
    logic [7:0] pre_hb78_reg;
    logic [7:0] gain_hb14_reg;
    logic [7:0] gain_hb58_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    dlpc_loop_type [3:0] loop_reg;
    dlpc_loop_type [3:0] loop_next;
    dlpc_pre_type [1:0] pre_reg;
    dlpc_pre_type [1:0] pre_next;

    wire wr_pre56 = clk_en && reg_wr && reg_addr == `DLPC_ADDR_PRE_HB56;
    wire wr_pre78 = clk_en && reg_wr && reg_addr == `DLPC_ADDR_PRE_HB78;
    wire wr_g14 = clk_en && reg_wr && reg_addr == `DLPC_ADDR_GAIN_HB14;
    wire wr_g58 = clk_en && reg_wr && reg_addr == `DLPC_ADDR_GAIN_HB58;

    // Reads return stored values; unmapped offsets read zero
    always_comb begin
        if (reg_addr == `DLPC_ADDR_PRE_HB56) begin
            rdata_next = pre_hb56_reg;
        end else if (reg_addr == `DLPC_ADDR_PRE_HB78) begin
            rdata_next = pre_hb78_reg;
        end else if (reg_addr == `DLPC_ADDR_GAIN_HB14) begin
            rdata_next = gain_hb14_reg;
        end else if (reg_addr == `DLPC_ADDR_GAIN_HB58) begin
            rdata_next = gain_hb58_reg;
        end else begin
            rdata_next = 8'h00;
        end
    end

    // Reset values
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pre_hb56_reg <= `DLPC_RST_PRE;
            pre_hb78_reg <= `DLPC_RST_PRE;
            gain_hb14_reg <= `DLPC_RST_GAIN;
            gain_hb58_reg <= `DLPC_RST_GAIN;
            rdata_reg <= 8'h00;
        end else if (clk_en) begin
            if (wr_pre56) pre_hb56_reg <= reg_wdata;
            if (wr_pre78) pre_hb78_reg <= reg_wdata;
            if (wr_g14) gain_hb14_reg <= reg_wdata;
            if (wr_g58) gain_hb58_reg <= reg_wdata;
            if (reg_rd) rdata_reg <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Loop settings, one nibble per pair

    // Upper nibble serves the lower-numbered pair
    wire [15:0] nibbles = {gain_hb14_reg, gain_hb58_reg};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_loop
            wire [3:0] nib = nibbles[15 - 4 * gi -: 4];
            wire [1:0] gcode = nib[`DLPC_NIB_GAIN_MSB -: 2];
            // Loop runs only while enabled
            assign loop_next[gi].enable = nib[`DLPC_NIB_EN];
            // One-bit or measured error
            assign loop_next[gi].err_actual = nib[`DLPC_NIB_ERR];
            // Gain is code plus one
            assign loop_next[gi].gain = {1'b0, gcode} + 3'h1;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Pre-charge settings for pairs 5-6 and 7-8

    wire [15:0] pre_bytes = {pre_hb56_reg, pre_hb78_reg};
    wire [11:0] delay_set = {onoff_delay_setting_hb56,
                             onoff_delay_setting_hb78};

    generate
        for (gi = 0; gi < 2; gi++) begin : g_pre
            wire [7:0] pb = pre_bytes[15 - 8 * gi -: 8];
            wire [1:0] ct = pb[`DLPC_PRE_CT_MSB -: 2];
            wire [1:0] dt = pb[`DLPC_PRE_DT_MSB -: 2];
            wire [5:0] set = delay_set[11 - 6 * gi -: 6];
            // Delay reference is 140 ns per step
            wire [13:0] ref_ns = 14'(`DLPC_STEP_NS * {8'h00, set});
            // Fraction is (code + 1) eighths of the reference
            wire [16:0] ct_prod = 17'({3'h0, ref_ns} * 17'({1'b0, ct} + 3'h1));
            wire [16:0] dt_prod = 17'({3'h0, ref_ns} * 17'({1'b0, dt} + 3'h1));
            // Currents double per code step from 4 mA
            assign pre_next[gi].charge_ma =
                `DLPC_BASE_MA << pb[`DLPC_PRE_CI_MSB -: 2];
            assign pre_next[gi].discharge_ma =
                `DLPC_BASE_MA << pb[`DLPC_PRE_DI_MSB -: 2];
            assign pre_next[gi].delay_ref_ns = ref_ns;
            assign pre_next[gi].charge_ns = ct_prod[16:`DLPC_FRAC_SHIFT];
            assign pre_next[gi].discharge_ns = dt_prod[16:`DLPC_FRAC_SHIFT];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Settings in force, loaded during reset and otherwise only at a pair's
    // switching edge, so a write never changes drive in the middle of a transition

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            loop_reg <= loop_next;
            pre_reg <= pre_next;
        end else if (clk_en) begin
            for (int i = 0; i < 4; i++) begin
                if (switch_edge[i]) loop_reg[i] <= loop_next[i];
            end
            for (int i = 0; i < 2; i++) begin
                if (switch_edge[i + 2]) pre_reg[i] <= pre_next[i];
            end
        end
    end

    assign reg_rdata = rdata_reg;
    assign loop_cfg = loop_reg;
    assign pre_cfg = pre_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    property p_reset_values;
        $fell(sys_rst) |-> pre_hb56_reg == 8'hF6 && pre_hb78_reg == 8'hF6
            && gain_hb14_reg == 8'h11 && gain_hb58_reg == 8'h11
            && !loop_cfg[0].enable && loop_cfg[3].gain == 3'h2;
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("bank not at reset values after reset");

    property p_write_readback;
        clk_en && reg_wr && !reg_rd && reg_addr == 6'h34
            ##1 clk_en && reg_rd && !reg_wr && reg_addr == 6'h34
            |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_write_readback: assert property (p_write_readback)
        else $error("readback differs from last write");

    property p_unmapped_zero;
        clk_en && reg_rd && reg_addr == 6'h35 |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero)
        else $error("unmapped offset did not read zero");

    property p_enable_nibble;
        clk_en && switch_edge[2] |=> loop_cfg[2].enable
            == $past(gain_hb58_reg[7]) && loop_cfg[3].enable
            == $past(gain_hb58_reg[3] && switch_edge[3] || !switch_edge[3]
            && loop_cfg[3].enable);
    endproperty
    a_enable_nibble: assert property (p_enable_nibble)
        else $error("enable taken from wrong nibble");

    property p_err_mode;
        clk_en && switch_edge[1] |=> loop_cfg[1].err_actual
            == $past(gain_hb14_reg[2]);
    endproperty
    a_err_mode: assert property (p_err_mode)
        else $error("error mode not taken at switching edge");

    property p_gain_map;
        clk_en && switch_edge[0] |=> loop_cfg[0].gain
            == 3'($past(gain_hb14_reg[5:4])) + 3'h1;
    endproperty
    a_gain_map: assert property (p_gain_map)
        else $error("gain not code plus one");

    property p_hold_between_edges;
        !(clk_en && switch_edge[3]) |=> $stable(loop_cfg[3])
            && $stable(pre_cfg[1]);
    endproperty
    a_hold_between_edges: assert property (p_hold_between_edges)
        else $error("settings changed without a switching edge");

    property p_currents;
        clk_en && switch_edge[2] |=> pre_cfg[0].charge_ma
            == 6'h04 << $past(pre_hb56_reg[3:2]) && pre_cfg[0].discharge_ma
            == 6'h04 << $past(pre_hb56_reg[1:0]);
    endproperty
    a_currents: assert property (p_currents)
        else $error("initial current decode wrong");

    // Expected times built from the setting, not from the output reference
    property p_times;
        clk_en && switch_edge[3] |=> int'(pre_cfg[1].delay_ref_ns)
            == 140 * int'($past(onoff_delay_setting_hb78))
            && int'(pre_cfg[1].charge_ns) == 140
            * int'($past(onoff_delay_setting_hb78))
            * (int'($past(pre_hb78_reg[7:6])) + 1) / 8
            && int'(pre_cfg[1].discharge_ns) == 140
            * int'($past(onoff_delay_setting_hb78))
            * (int'($past(pre_hb78_reg[5:4])) + 1) / 8;
    endproperty
    a_times: assert property (p_times)
        else $error("pre-charge timing wrong");

    property p_times_hb56;
        clk_en && switch_edge[2] |=> int'(pre_cfg[0].delay_ref_ns)
            == 140 * int'($past(onoff_delay_setting_hb56))
            && int'(pre_cfg[0].charge_ns) == 140
            * int'($past(onoff_delay_setting_hb56))
            * (int'($past(pre_hb56_reg[7:6])) + 1) / 8
            && int'(pre_cfg[0].discharge_ns) == 140
            * int'($past(onoff_delay_setting_hb56))
            * (int'($past(pre_hb56_reg[5:4])) + 1) / 8;
    endproperty
    a_times_hb56: assert property (p_times_hb56)
        else $error("pre-charge timing wrong for pair 5-6");

    property p_currents_hb78;
        clk_en && switch_edge[3] |=> pre_cfg[1].charge_ma
            == 6'h04 << $past(pre_hb78_reg[3:2]) && pre_cfg[1].discharge_ma
            == 6'h04 << $past(pre_hb78_reg[1:0]);
    endproperty
    a_currents_hb78: assert property (p_currents_hb78)
        else $error("initial current decode wrong for pair 7-8");

    property p_enable_hb12;
        clk_en && switch_edge[0] |=> loop_cfg[0].enable
            == $past(gain_hb14_reg[7]);
    endproperty
    a_enable_hb12: assert property (p_enable_hb12)
        else $error("enable for pair 1-2 from wrong bit");

    property p_enable_hb34;
        clk_en && switch_edge[1] |=> loop_cfg[1].enable
            == $past(gain_hb14_reg[3]);
    endproperty
    a_enable_hb34: assert property (p_enable_hb34)
        else $error("enable for pair 3-4 from wrong bit");

    property p_err_hb56;
        clk_en && switch_edge[2] |=> loop_cfg[2].err_actual
            == $past(gain_hb58_reg[6]);
    endproperty
    a_err_hb56: assert property (p_err_hb56)
        else $error("error mode for pair 5-6 from wrong bit");

    property p_err_hb78;
        clk_en && switch_edge[3] |=> loop_cfg[3].err_actual
            == $past(gain_hb58_reg[2]);
    endproperty
    a_err_hb78: assert property (p_err_hb78)
        else $error("error mode for pair 7-8 from wrong bit");

    property p_gain_hb78;
        clk_en && switch_edge[3] |=> loop_cfg[3].gain
            == 3'($past(gain_hb58_reg[1:0])) + 3'h1;
    endproperty
    a_gain_hb78: assert property (p_gain_hb78)
        else $error("gain for pair 7-8 not code plus one");

    property p_hold_hb56;
        !(clk_en && switch_edge[2]) |=> $stable(loop_cfg[2])
            && $stable(pre_cfg[0]);
    endproperty
    a_hold_hb56: assert property (p_hold_hb56)
        else $error("pair 5-6 settings changed without a switching edge");

    // Read data must stand until the next accepted read
    property p_rdata_hold;
        !(clk_en && reg_rd) |=> $stable(reg_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data changed without a read");

    property p_write_lands;
        clk_en && reg_wr && reg_addr == 6'h31 |=> pre_hb56_reg
            == $past(reg_wdata);
    endproperty
    a_write_lands: assert property (p_write_lands)
        else $error("write to pair 5-6 pre-charge byte lost");

    // Low enable freezes registers and settings alike
    property p_freeze;
        !clk_en |=> $stable(pre_hb56_reg) && $stable(pre_hb78_reg)
            && $stable(gain_hb14_reg) && $stable(gain_hb58_reg)
            && $stable(loop_cfg) && $stable(pre_cfg);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state changed while clock enable low");

endmodule

`default_nettype wire

// File: core/dlpc_defs.svh
// Constants for the delay-reduction-loop pre-charge configuration bank.
// Assumes an 8-bit register port at the printed register offsets.
// Notes on behaviour
// - Initial charge current code maps 00=4, 01=8, 10=16, 11=32 mA.
// - Initial discharge current code maps 00=4, 01=8, 10=16, 11=32 mA.
// - Charge time is 1/8, 1/4, 3/8 or 1/2 of on/off delay.
// - Discharge time is 1/8, 1/4, 3/8 or 1/2 of on/off delay.
// - Loop runs for a pair only while its enable bit is set; resets off.
// - Error bit 0 limits correction to one bit, 1 uses measured error.
// - Gain code 00..11 means gain 1..4; resets to code 01.
// - Pre-charge register resets with times 11, charge 01, discharge 10.
// - Pairs 1-4 share one byte, 5-8 another; upper nibble is lower pair.
// - On/off delay reference is 140 ns times the delay setting.
`ifndef DLPC_DEFS_SVH
`define DLPC_DEFS_SVH

// Register offsets
`define DLPC_ADDR_PRE_HB56 6'h31
`define DLPC_ADDR_PRE_HB78 6'h32
`define DLPC_ADDR_GAIN_HB14 6'h33
`define DLPC_ADDR_GAIN_HB58 6'h34

// Reset values
`define DLPC_RST_PRE 8'hF6
`define DLPC_RST_GAIN 8'h11

// Field positions, pre-charge register
`define DLPC_PRE_CT_MSB 7
`define DLPC_PRE_DT_MSB 5
`define DLPC_PRE_CI_MSB 3
`define DLPC_PRE_DI_MSB 1

// Field positions inside a loop nibble
`define DLPC_NIB_EN 3
`define DLPC_NIB_ERR 2
`define DLPC_NIB_GAIN_MSB 1

// Currents and timing
`define DLPC_BASE_MA 6'h04
`define DLPC_STEP_NS 14'h008C
`define DLPC_FRAC_SHIFT 3

`endif

// File: core/dlpc_pkg.sv
// Types shared by the pre-charge configuration bank.
// Assumes the constants header is compiled alongside.
`default_nettype none

package dlpc_pkg;

    // Settings in force for one bridge pair's loop
    typedef struct packed {
        logic enable;
        logic err_actual;
        logic [2:0] gain;
    } dlpc_loop_type;

    // Pre-charge settings in force for one bridge pair
    typedef struct packed {
        logic [5:0] charge_ma;
        logic [5:0] discharge_ma;
        logic [13:0] delay_ref_ns;
        logic [13:0] charge_ns;
        logic [13:0] discharge_ns;
    } dlpc_pre_type;

endpackage

`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the pre-charge configuration bank.
// Assumes the package and the constants header are compiled first.
`include "dlpc_defs.svh"
`default_nettype none

module tb
    import dlpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [5:0] reg_addr = 6'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic [3:0] switch_edge = 4'h0;
    logic [5:0] onoff_delay_setting_hb56 = 6'h0A;
    logic [5:0] onoff_delay_setting_hb78 = 6'h15;
    dlpc_loop_type [3:0] loop_cfg;
    dlpc_pre_type [1:0] pre_cfg;
    // Model of the four registers, index 0 is the hb56 pre-charge byte
    logic [7:0] regs [4];
    int fail_count = 0;
    int tests_run = 0;
    integer seed = 32'hB9E5;

    always #2 core_clk = ~core_clk;

    dlpc_bank dlpc_bank_inst (
        .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .switch_edge(switch_edge),
        .onoff_delay_setting_hb56(onoff_delay_setting_hb56),
        .onoff_delay_setting_hb78(onoff_delay_setting_hb78),
        .loop_cfg(loop_cfg), .pre_cfg(pre_cfg)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        if (fail_count == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string name, input logic [127:0] seen,
                       input logic [127:0] exp);
        tests_run++;
        if (seen !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, seen);
            fail_count++;
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // Data is taken just after the edge that accepts the read
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Write then read one offset on back-to-back edges
    task automatic wr_rd(input logic [5:0] a, input logic [7:0] v,
                         output logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic sw;
        @(posedge core_clk);
        switch_edge <= 4'hF;
        @(posedge core_clk);
        switch_edge <= 4'h0;
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [5:0] cur_f(input logic [1:0] c);
        return `DLPC_BASE_MA << c;
    endfunction

    function automatic logic [13:0] ref_f(input logic [5:0] s);
        return 14'(s) * `DLPC_STEP_NS;
    endfunction

    // Floor of ref times (code+1)/8, widened so the product cannot wrap
    function automatic logic [13:0] time_f(input logic [13:0] r,
                                           input logic [1:0] c);
        logic [16:0] p;
        p = 17'(r) * 17'(c + 3'h1);
        return 14'(p >> `DLPC_FRAC_SHIFT);
    endfunction

    task automatic check_out;
        logic [7:0] w;
        logic [3:0] nib;
        logic [13:0] r;
        dlpc_pre_type p;
        for (int i = 0; i < 4; i++) begin
            w = regs[2 + i / 2];
            nib = (i % 2) ? w[3:0] : w[7:4];
            chk("loop_enable", loop_cfg[i].enable, nib[3]);
            chk("loop_error", loop_cfg[i].err_actual, nib[2]);
            chk("loop_gain", loop_cfg[i].gain, nib[1:0] + 3'h1);
        end
        for (int j = 0; j < 2; j++) begin
            w = regs[j];
            r = ref_f(j ? onoff_delay_setting_hb78 : onoff_delay_setting_hb56);
            p = pre_cfg[j];
            chk("charge_ma", p.charge_ma, cur_f(w[3:2]));
            chk("discharge_ma", p.discharge_ma, cur_f(w[1:0]));
            chk("delay_ref_ns", p.delay_ref_ns, r);
            chk("charge_ns", p.charge_ns, time_f(r, w[7:6]));
            chk("discharge_ns", p.discharge_ns, time_f(r, w[5:4]));
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Hang guard; the whole sequence needs well under this
    initial begin
        repeat (5000) @(posedge core_clk);
        fail_count++;
        end_sim();
    end

    initial begin
        logic [7:0] d;
        logic [7:0] v;
        dlpc_loop_type [3:0] old_loop;
        dlpc_pre_type [1:0] old_pre;
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        regs = '{`DLPC_RST_PRE, `DLPC_RST_PRE, `DLPC_RST_GAIN, `DLPC_RST_GAIN};
        #1 check_out();
        for (int k = 0; k < 4; k++) begin
            rd(`DLPC_ADDR_PRE_HB56 + 6'(k), d);
            chk("reset_value", d, regs[k]);
        end
        rd(6'h35, d);
        chk("unmapped_read", d, 8'h00);
        // First four passes walk every code of every field
        for (int n = 0; n < 24; n++) begin
            old_loop = loop_cfg;
            old_pre = pre_cfg;
            @(posedge core_clk);
            onoff_delay_setting_hb56 <= n < 4 ? 6'h3F : 6'($random(seed));
            onoff_delay_setting_hb78 <= n < 4 ? 6'h01 : 6'($random(seed));
            for (int k = 0; k < 4; k++) begin
                v = n < 4 ? {4{2'(n)}} : 8'($random(seed));
                regs[k] = v;
                wr(`DLPC_ADDR_PRE_HB56 + 6'(k), v);
            end
            for (int k = 0; k < 4; k++) begin
                rd(`DLPC_ADDR_PRE_HB56 + 6'(k), d);
                chk("readback", d, regs[k]);
            end
            chk("loop_held", loop_cfg, old_loop);
            chk("pre_held", pre_cfg, old_pre);
            sw();
            check_out();
        end
        // Back-to-back write and read on one offset
        v = 8'($random(seed));
        regs[3] = v;
        wr_rd(`DLPC_ADDR_GAIN_HB58, v, d);
        chk("write_then_read", d, v);
        // Writes and switching while the clock enable is low are dropped
        @(posedge core_clk);
        clk_en <= 1'b0;
        old_loop = loop_cfg;
        old_pre = pre_cfg;
        wr(`DLPC_ADDR_GAIN_HB58, ~regs[3]);
        sw();
        @(posedge core_clk);
        clk_en <= 1'b1;
        chk("frozen_loop", loop_cfg, old_loop);
        chk("frozen_pre", pre_cfg, old_pre);
        rd(`DLPC_ADDR_GAIN_HB58, d);
        chk("frozen_write", d, regs[3]);
        // Second reset in mid-run returns every field to its reset value
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        regs = '{`DLPC_RST_PRE, `DLPC_RST_PRE, `DLPC_RST_GAIN, `DLPC_RST_GAIN};
        #1 check_out();
        rd(`DLPC_ADDR_GAIN_HB14, d);
        chk("reset_again", d, `DLPC_RST_GAIN);
        end_sim();
    end

endmodule

`default_nettype wire
